// ===== rtl/wsc_pkg.sv
/*
 * wsc_pkg: constants for the watchdog / sleep / wake control block.
 * assumes: one 125 MHz core clock, asynchronous active-low reset.
 */
package wsc_pkg;
    // table-read address map
    localparam logic [21:0] WSC_USER_ID_FIRST = 22'h20_0000;
    localparam logic [21:0] WSC_USER_ID_LAST = 22'h20_0004;
    localparam logic [21:0] WSC_DEV_IDENT_LOW_ADDR = 22'h3f_fffe;
    localparam logic [21:0] WSC_DEV_IDENT_HIGH_ADDR = 22'h3f_ffff;
    // register fields and reset values
    localparam int WSC_SW_EN_BIT = 0;
    localparam logic [7:0] WSC_SW_CONTROL_RST = 8'h00;
    localparam int WSC_FLAG_EXPIRY_BIT = 3;
    localparam int WSC_FLAG_SLEEP_BIT = 2;
    // oscillator start-up delay, in oscillator periods; core clock stands in for it
    localparam int WSC_OSC_STARTUP_PERIODS = 1024;
    localparam logic [10:0] WSC_OSC_STARTUP_CYCLES = 11'(WSC_OSC_STARTUP_PERIODS);
    // last base watchdog count in rc ticks, so the base period is 256 ticks (value is a neutral default)
    localparam logic [7:0] WSC_WDT_BASE_TICKS = 8'hff;
    // power state machine
    typedef enum logic [1:0] {
        WSC_RUN = 2'b00,
        WSC_SLEEP = 2'b01,
        WSC_STARTUP = 2'b10
    } wsc_state_t;
endpackage : wsc_pkg

// ===== rtl/wsc_watchdog_sleep_wake_control.sv
/*
 * wsc_watchdog_sleep_wake_control: sleep entry, wake sequencing, watchdog,
 * status flags and the read-only identification locations.
 * assumes: core gives one-cycle instruction strobes on clk; the watchdog rc
 * oscillator, reset pin and wake events arrive asynchronously as levels.
 */
`timescale 1ns/100ps
`default_nettype none
module wsc_watchdog_sleep_wake_control #(
    parameter logic [7:0] PART_NUMBER_LOW_REV = 8'h00, // arbitrary value
    parameter logic [7:0] PART_NUMBER_HIGH = 8'h00     // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // programmed configuration
    input wire logic cfg_watchdog_enable,
    input wire logic [2:0] watchdog_postscale_sel,
    input wire logic cfg_crystal_osc,
    input wire logic code_protect_n,
    input wire logic [39:0] user_id_bytes,
    // core instruction strobes
    input wire logic sleep_instr,
    input wire logic kick_watchdog_instr,
    input wire logic global_irq_enable,
    input wire logic [21:0] pc_in,
    // control register access
    input wire logic sw_ctrl_wr,
    input wire logic [7:0] sw_ctrl_wdata,
    // flag register access
    input wire logic flags_rd_clear_n,
    // table read
    input wire logic table_read_instr,
    input wire logic verify_mode,
    input wire logic [21:0] table_addr,
    input wire logic [7:0] prog_mem_data,
    // asynchronous sources
    input wire logic master_clear_pin,
    input wire logic wdt_rc_clk,
    input wire logic [9:0] periph_wake_req,
    input wire logic [9:0] periph_wake_en,
    input wire logic irq_pending,
    // outputs
    output logic [7:0] watchdog_sw_control,
    output logic [7:0] reset_cause_flags,
    output logic [7:0] table_data,
    output logic table_valid,
    output logic osc_enable,
    output logic io_hold,
    output logic core_run,
    output logic [21:0] prefetch_addr,
    output logic take_vector,
    output logic device_reset
);
    // block outline
    // - one power state machine: run, sleep, start-up
    // - one watchdog: rc tick counter plus postscaler
    // - two low-true status flags in the flags output
    // - a table-read port for id bytes and memory

    // the core clock keeps running here through sleep;
    // only the main oscillator driver stops (osc_enable)
    // io_hold asks the port logic to freeze its outputs
    // core_run is low from sleep entry to end of wake-up

    // clock domains
    // rc clock, reset pin and wake sources are foreign
    // to clk and are filtered before any use
    // irq_pending is core logic on clk: no filter
    // trade-off: the filter costs a few cycles of wake
    // latency, small against any real wake-up time

    // limitation: the rc clock is sampled on clk, so it
    // must stay well below half the core clock rate

    // three-stage synchronisers on asynchronous levels
    logic [2:0] rstpin_s_q; // reset pin stages
    logic [2:0] rc_s_q; // rc clock stages
    logic [2:0] wake_s_q; // wake source stages
    logic rstpin_q; // filtered reset pin level
    logic rc_q; // filtered rc clock level
    logic wake_q; // filtered peripheral wake
    logic [2:0] rstpin_d3;
    logic [2:0] rc_d3;
    logic [2:0] wake_d3;

    // only enabled, clock-independent sources count
    wire periph_wake_raw = |(periph_wake_req & periph_wake_en);
    assign rstpin_d3 = {rstpin_s_q[1:0], master_clear_pin};
    assign rc_d3 = {rc_s_q[1:0], wdt_rc_clk};
    assign wake_d3 = {wake_s_q[1:0], periph_wake_raw};

    // stage 1 feeds only stage 2; change accepted when stages 2 and 3 agree
    // reset pin idles high, so its stages reset high: no false edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstpin_s_q <= 3'h7;
            rc_s_q <= 3'h0;
            wake_s_q <= 3'h0;
        end else begin
            rstpin_s_q <= rstpin_d3;
            rc_s_q <= rc_d3;
            wake_s_q <= wake_d3;
        end
    end

    // agreement filters
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstpin_q <= 1'b1;
            rc_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            if (rstpin_s_q[1] == rstpin_s_q[2]) rstpin_q <= rstpin_s_q[2];
            if (rc_s_q[1] == rc_s_q[2]) rc_q <= rc_s_q[2];
            if (wake_s_q[1] == wake_s_q[2]) wake_q <= wake_s_q[2];
        end
    end

    // rc tick: rising edge of the filtered rc clock
    // reset pin event: falling edge of its filtered level
    logic rc_prev_q;
    logic rstpin_prev_q;
    wire rc_tick = rc_q & ~rc_prev_q;
    wire rstpin_fall = ~rstpin_q & rstpin_prev_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rc_prev_q <= 1'b0;
            rstpin_prev_q <= 1'b1;
        end else begin
            rc_prev_q <= rc_q;
            rstpin_prev_q <= rstpin_q;
        end
    end

    // state and registers
    wsc_pkg::wsc_state_t state_q, state_d;
    logic sw_en_q;
    logic expiry_flag_q;  // set means no expiry
    logic sleep_flag_q;   // set means no sleep executed
    logic [7:0] wdt_cnt_q;
    logic [6:0] post_cnt_q;
    logic [10:0] ost_cnt_q;

    // watchdog runs if config or software says so
    wire wdt_on = cfg_watchdog_enable | sw_en_q;

    // postscale ratio from programmed config, 1:128 down to 1:1
    // post_max is the last postscaler count before expiry
    // select 0 would need a 128 shift, so it is special-cased
    // no software path reaches this: fixed at programming
    // the full period is base ticks times the ratio

    // hazard: changing the select while running gives one
    // period of odd length; config is static in practice

    logic [6:0] post_max;
    assign post_max = (watchdog_postscale_sel == 3'h0) ? 7'h7f :
                      7'(8'h01 << (3'h7 - watchdog_postscale_sel)) - 7'h01;

    // sleep taken only when no enabled interrupt already pending
    wire sleep_go = sleep_instr & (state_q == wsc_pkg::WSC_RUN) & ~irq_pending;
    wire wdt_clear = sleep_go | kick_watchdog_instr;
    wire wdt_expire = wdt_on & rc_tick & (wdt_cnt_q == wsc_pkg::WSC_WDT_BASE_TICKS)
                      & (post_cnt_q == post_max);
    wire int_wake = wake_q | irq_pending;
    wire asleep = (state_q == wsc_pkg::WSC_SLEEP);

    // watchdog counter and postscaler keep running in sleep
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdt_cnt_q <= 8'h00;
            post_cnt_q <= 7'h00;
        end else if (wdt_clear || !wdt_on || wdt_expire) begin
            wdt_cnt_q <= 8'h00;
            post_cnt_q <= 7'h00;
        end else if (rc_tick) begin
            wdt_cnt_q <= wdt_cnt_q + 8'h01;
            if (wdt_cnt_q == wsc_pkg::WSC_WDT_BASE_TICKS) post_cnt_q <= post_cnt_q + 7'h01;
        end
    end

    // software control register: only bit 0 stored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) sw_en_q <= wsc_pkg::WSC_SW_CONTROL_RST[0];
        else if (sw_ctrl_wr) sw_en_q <= sw_ctrl_wdata[wsc_pkg::WSC_SW_EN_BIT];
    end

    // power state machine
    // run: core executes; a taken sleep goes to sleep
    // sleep: oscillator off, ports held, watchdog running
    // start-up: crystal settles before the core resumes
    // the reset pin forces run from any state

    // a watchdog wake and an interrupt wake take the same
    // path; only the flags and take_vector tell them apart

    // hazard: a late interrupt lands in sleep with int_wake
    // already high, so sleep lasts one cycle: sleep entry
    // is still complete, flags and watchdog already done

    // limitation: rc and external clock modes skip the
    // start-up wait entirely

    always_comb begin
        state_d = state_q;
        case (state_q)
            wsc_pkg::WSC_RUN: begin
                if (sleep_go) state_d = wsc_pkg::WSC_SLEEP;
            end
            wsc_pkg::WSC_SLEEP: begin
                // reset pin handled as a full reset below
                if (int_wake || wdt_expire)
                    state_d = cfg_crystal_osc ? wsc_pkg::WSC_STARTUP : wsc_pkg::WSC_RUN;
            end
            wsc_pkg::WSC_STARTUP: begin
                if (ost_cnt_q == wsc_pkg::WSC_OSC_STARTUP_CYCLES - 11'h001)
                    state_d = wsc_pkg::WSC_RUN;
            end
            default: state_d = wsc_pkg::WSC_RUN;
        endcase
        if (rstpin_fall) state_d = wsc_pkg::WSC_RUN;
    end

    // state and start-up counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= wsc_pkg::WSC_RUN;
            ost_cnt_q <= 11'h000;
        end else begin
            state_q <= state_d;
            ost_cnt_q <= (state_q == wsc_pkg::WSC_STARTUP) ? ost_cnt_q + 11'h001 : 11'h000;
        end
    end

    // status flags: power-up sets both; sleep clears the sleep
    // flag and sets the expiry flag; expiry clears the expiry flag
    // a hardware event wins over the flags_rd_clear_n re-arm in the same cycle

    // both flags are low-true: set means the event did not occur
    // software learns of a no-op sleep from a sleep flag still set
    // a no-op sleep touches neither flag, so the test is reliable

    // the flags reach the output one cycle after they change

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sleep_flag_q <= 1'b1;
            expiry_flag_q <= 1'b1;
        end else begin
            if (sleep_go) begin
                sleep_flag_q <= 1'b0;
                expiry_flag_q <= 1'b1;
            end else if (wdt_expire) begin
                expiry_flag_q <= 1'b0;
            end else if (!flags_rd_clear_n) begin
                sleep_flag_q <= 1'b1;
                expiry_flag_q <= 1'b1;
            end
        end
    end

    // table read decode
    // id locations win over memory: they stay readable
    // even while the memory array is code protected
    // memory reads in verify mode need protection off;
    // normal execution may always read its own memory
    // anything refused reads back as zero

    // user id bytes are packed lowest address first

    wire in_user_id = (table_addr >= wsc_pkg::WSC_USER_ID_FIRST) &&
                      (table_addr <= wsc_pkg::WSC_USER_ID_LAST);
    wire [2:0] user_idx = table_addr[2:0];
    wire is_id_low = table_addr == wsc_pkg::WSC_DEV_IDENT_LOW_ADDR;
    wire is_id_high = table_addr == wsc_pkg::WSC_DEV_IDENT_HIGH_ADDR;
    wire mem_allowed = ~verify_mode | code_protect_n;
    logic [7:0] table_d;
    always_comb begin
        table_d = 8'h00;
        if (in_user_id) table_d = user_id_bytes[{user_idx, 3'b000} +: 8];
        else if (is_id_low) table_d = PART_NUMBER_LOW_REV;
        else if (is_id_high) table_d = PART_NUMBER_HIGH;
        else if (mem_allowed) table_d = prog_mem_data;
    end

    // output registers
    // every output comes straight from a flip-flop
    // power outputs follow the next state, so they change
    // on the same edge as the state itself

    // osc_enable and io_hold are exact complements

    // prefetch address is captured on every sleep strobe,
    // taken or not, since the core fetches either way

    // take_vector pulses on an interrupt wake with the
    // global enable set; otherwise the core goes in-line

    // device_reset pulses for a reset-pin event and for
    // an expiry while awake; an expiry in sleep only wakes

    // table_data holds its last value between reads

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_sw_control <= 8'h00;
            reset_cause_flags <= 8'h0c;
            table_data <= 8'h00;
            table_valid <= 1'b0;
            osc_enable <= 1'b1;
            io_hold <= 1'b0;
            core_run <= 1'b1;
            prefetch_addr <= 22'h00_0000;
            take_vector <= 1'b0;
            device_reset <= 1'b0;
        end else begin
            watchdog_sw_control <= {7'h00, sw_en_q};
            reset_cause_flags <= {4'h0, expiry_flag_q, sleep_flag_q, 2'b00};
            table_valid <= table_read_instr;
            if (table_read_instr) table_data <= table_d;
            osc_enable <= (state_d != wsc_pkg::WSC_SLEEP);
            io_hold <= (state_d == wsc_pkg::WSC_SLEEP);
            core_run <= (state_d == wsc_pkg::WSC_RUN);
            if (sleep_instr) prefetch_addr <= pc_in + 22'h00_0002;
            take_vector <= asleep & int_wake & global_irq_enable;
            device_reset <= (wdt_expire & ~asleep) | rstpin_fall;
        end
    end
endmodule : wsc_watchdog_sleep_wake_control
`default_nettype wire

// ===== testbench/wsc_watchdog_properties.sv
/* wsc_watchdog_properties: port assertions for the sleep / wake block.
   assumes: bound to the top module; one clk domain; arst_n low resets. */
`timescale 1ns/100ps
`default_nettype none
module wsc_watchdog_properties #(
    parameter logic [7:0] PART_NUMBER_LOW_REV = 8'h00,
    parameter logic [7:0] PART_NUMBER_HIGH = 8'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // core side
    input wire logic sleep_instr,
    input wire logic irq_pending,
    input wire logic cfg_crystal_osc,
    input wire logic flags_rd_clear_n,
    input wire logic [21:0] pc_in,
    input wire logic sw_ctrl_wr,
    input wire logic [7:0] sw_ctrl_wdata,
    input wire logic table_read_instr,
    input wire logic [21:0] table_addr,
    // block outputs
    input wire logic [7:0] watchdog_sw_control,
    input wire logic [7:0] reset_cause_flags,
    input wire logic [7:0] table_data,
    input wire logic table_valid,
    input wire logic osc_enable,
    input wire logic io_hold,
    input wire logic core_run,
    input wire logic [21:0] prefetch_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // a sleep that is really taken: running, nothing pending
    sequence s_sleep_go;
        sleep_instr && core_run && !irq_pending;
    endsequence
    // a lone read, so the end of the valid pulse can be seen
    sequence s_lone_read;
        table_read_instr ##1 !table_read_instr;
    endsequence
    a_sleep_entry: assert property (s_sleep_go |=> !osc_enable && io_hold && !core_run)
        else $error("sleep entry outputs wrong");
    a_sleep_flags: assert property (s_sleep_go |=> ##1 reset_cause_flags[3:2] == 2'b10)
        else $error("flags wrong after sleep");
    a_sleep_prefetch: assert property (s_sleep_go |=> prefetch_addr == $past(pc_in) + 22'h2)
        else $error("prefetch address wrong");
    // clear strobe excluded: it would legally re-arm the flags
    a_sleep_noop: assert property (sleep_instr && core_run && irq_pending && flags_rd_clear_n
        |=> core_run && $stable(reset_cause_flags[3:2]))
        else $error("pending sleep not a no-op");
    a_ctrl_upper: assert property (watchdog_sw_control[7:1] == 7'h0)
        else $error("control upper bits not zero");
    a_ctrl_write: assert property (sw_ctrl_wr
        |=> ##1 watchdog_sw_control[0] == $past(sw_ctrl_wdata[0], 2))
        else $error("control write lost");
    a_read_pulse: assert property (s_lone_read |-> table_valid ##1 !table_valid)
        else $error("table valid not one cycle");
    a_ident_low: assert property (table_read_instr && table_addr == 22'h3f_fffe
        |=> table_data == PART_NUMBER_LOW_REV)
        else $error("low ident byte wrong");
    a_ident_high: assert property (table_read_instr && table_addr == 22'h3f_ffff
        |=> table_data == PART_NUMBER_HIGH)
        else $error("high ident byte wrong");
    // without a crystal there is no start-up wait, so wake is prompt
    a_irq_wake: assert property (!core_run && irq_pending && !cfg_crystal_osc
        |-> ##[1:6] core_run)
        else $error("interrupt wake too slow");
endmodule : wsc_watchdog_properties
bind wsc_watchdog_sleep_wake_control wsc_watchdog_properties #(
    .PART_NUMBER_LOW_REV(PART_NUMBER_LOW_REV), .PART_NUMBER_HIGH(PART_NUMBER_HIGH)) prop_u (.*);
`default_nettype wire

// ===== testbench/wsc_wake_source_model.sv
/* wsc_wake_source_model: clockless wake sources and the watchdog rc clock.
   assumes: the bench commands the source levels; nothing else drives them. */
`timescale 1ns/100ps
`default_nettype none
module wsc_wake_source_model (
    // commanded source levels
    input wire logic [9:0] src_cmd,
    // to the block
    output logic [9:0] periph_wake_req,
    output logic wdt_rc_clk
);
    // sources need no core clock, so they change at arbitrary times
    always @(src_cmd) periph_wake_req = #7 src_cmd;
    // free-running rc, phase unrelated to clk; it keeps going in sleep
    initial begin
        wdt_rc_clk = 1'b0;
        forever #21.3 wdt_rc_clk = ~wdt_rc_clk;
    end
endmodule : wsc_wake_source_model
`default_nettype wire

// ===== testbench/wsc_watchdog_sleep_wake_control_tb_top.sv
/* wsc tb top: scenario tasks for the sleep / wake block.
   assumes: the source model gives rc clock and wake levels. */
`timescale 1ns/100ps
`default_nettype none
module wsc_watchdog_sleep_wake_control_tb_top;
    logic clk, arst_n, cfg_watchdog_enable, cfg_crystal_osc, code_protect_n, sleep_instr;
    logic kick_watchdog_instr, global_irq_enable, sw_ctrl_wr, flags_rd_clear_n, irq_pending;
    logic table_read_instr, verify_mode, master_clear_pin, table_valid, osc_enable, io_hold;
    logic core_run, take_vector, device_reset, wdt_rc_clk, seen_rst, seen_vec;
    logic [2:0] watchdog_postscale_sel;
    logic [9:0] periph_wake_req, periph_wake_en, src_cmd;
    logic [21:0] pc_in, table_addr, prefetch_addr;
    logic [39:0] user_id_bytes;
    logic [7:0] sw_ctrl_wdata, prog_mem_data, watchdog_sw_control, reset_cause_flags, table_data;
    int num_errors, n_tests;
    wsc_watchdog_sleep_wake_control #(.PART_NUMBER_LOW_REV(8'ha5), .PART_NUMBER_HIGH(8'h3c))
    dut_u (.clk, .arst_n, .cfg_watchdog_enable, .watchdog_postscale_sel, .cfg_crystal_osc,
        .code_protect_n, .user_id_bytes, .sleep_instr, .kick_watchdog_instr, .global_irq_enable,
        .pc_in, .sw_ctrl_wr, .sw_ctrl_wdata, .flags_rd_clear_n, .table_read_instr, .verify_mode,
        .table_addr, .prog_mem_data, .master_clear_pin, .wdt_rc_clk, .periph_wake_req,
        .periph_wake_en, .irq_pending, .watchdog_sw_control, .reset_cause_flags, .table_data,
        .table_valid, .osc_enable, .io_hold, .core_run, .prefetch_addr, .take_vector,
        .device_reset);
    wsc_wake_source_model src_u (.src_cmd, .periph_wake_req, .wdt_rc_clk);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // sticky monitors; go_sleep clears them at each sleep entry, not before each look
    always @(posedge clk) begin
        if (device_reset === 1'b1) seen_rst = 1'b1;
        if (take_vector === 1'b1) seen_vec = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic chk(input logic [21:0] got, input logic [21:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask : chk
    // bounded wait until the core runs again
    task automatic wait_run(input int m);
        repeat (m) if (core_run !== 1'b1) step(1);
    endtask : wait_run
    task automatic go_sleep();
        seen_rst = 1'b0;
        seen_vec = 1'b0;
        pc_in = 22'h00_1230;
        sleep_instr = 1'b1;
        step(1);
        sleep_instr = 1'b0;
    endtask : go_sleep
    task automatic rd(input logic [21:0] a, input logic [7:0] e);
        table_addr = a;
        table_read_instr = 1'b1;
        step(1);
        table_read_instr = 1'b0;
        chk(table_valid, 1'b1, "table valid");
        chk(table_data, e, "table data");
        step(1);
    endtask : rd
    task automatic t_regs();
        chk(watchdog_sw_control, 8'h00, "ctrl reset");
        chk(reset_cause_flags[3:2], 2'b11, "flags reset");
        sw_ctrl_wdata = 8'hff;
        sw_ctrl_wr = 1'b1;
        step(1);
        sw_ctrl_wdata = 8'h00;
        step(1);
        sw_ctrl_wr = 1'b0;
        chk(watchdog_sw_control, 8'h01, "ctrl write one");
        step(1);
        chk(watchdog_sw_control, 8'h00, "ctrl write zero");
        $display("test regs done");
    endtask : t_regs
    // enable low wakes on a peripheral, enable high on a late interrupt
    task automatic t_sleep(input logic irq_en);
        global_irq_enable = irq_en;
        periph_wake_en = 10'h000;
        go_sleep();
        chk(osc_enable, 1'b0, "osc off");
        chk(io_hold, 1'b1, "io held");
        chk(prefetch_addr, 22'h00_1232, "prefetch");
        src_cmd = 10'h208;
        step(20);
        chk(reset_cause_flags[3:2], 2'b10, "sleep flags");
        chk(core_run, 1'b0, "masked source woke");
        if (irq_en) irq_pending = 1'b1;
        else periph_wake_en = 10'h3ff;
        wait_run(20);
        step(10);
        chk(core_run, 1'b1, "no wake");
        chk(seen_vec, irq_en, "vector choice");
        chk(seen_rst, 1'b0, "wake reset");
        irq_pending = 1'b0;
        src_cmd = 10'h000;
        step(8);
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_noop();
        irq_pending = 1'b1;
        flags_rd_clear_n = 1'b0;
        step(1);
        flags_rd_clear_n = 1'b1;
        go_sleep();
        chk(core_run, 1'b1, "noop slept");
        chk(reset_cause_flags[3:2], 2'b11, "noop flags");
        irq_pending = 1'b0;
        $display("test noop done");
    endtask : t_noop
    task automatic t_crystal();
        cfg_crystal_osc = 1'b1;
        periph_wake_en = 10'h001;
        go_sleep();
        src_cmd = 10'h001;
        step(1000);
        chk(core_run, 1'b0, "startup too short");
        wait_run(100);
        chk(core_run, 1'b1, "startup too long");
        cfg_crystal_osc = 1'b0;
        src_cmd = 10'h000;
        periph_wake_en = 10'h000;
        step(8);
        $display("test crystal done");
    endtask : t_crystal
    task automatic t_pin();
        go_sleep();
        master_clear_pin = 1'b0;
        step(12);
        master_clear_pin = 1'b1;
        wait_run(20);
        chk(seen_rst, 1'b1, "pin no reset");
        chk(core_run, 1'b1, "pin no run");
        $display("test pin done");
    endtask : t_pin
    // config enable on, software enable off: watchdog still runs
    task automatic t_wdt();
        cfg_watchdog_enable = 1'b1;
        go_sleep();
        wait_run(3000);
        step(2);
        chk(core_run, 1'b1, "no wdt wake");
        chk(reset_cause_flags[3], 1'b0, "expiry flag");
        chk(seen_rst, 1'b0, "wdt wake reset");
        repeat (6) begin
            step(500);
            kick_watchdog_instr = 1'b1;
            step(1);
            kick_watchdog_instr = 1'b0;
        end
        chk(seen_rst, 1'b0, "kick failed");
        step(3000);
        chk(seen_rst, 1'b1, "no wdt reset");
        $display("test wdt done");
    endtask : t_wdt
    task automatic t_table();
        rd(22'h20_0000, 8'h00);
        code_protect_n = 1'b0;
        rd(22'h20_0004, 8'h44);
        rd(22'h3f_fffe, 8'ha5);
        rd(22'h3f_ffff, 8'h3c);
        rd(22'h00_0010, 8'h00);
        verify_mode = 1'b0;
        rd(22'h00_0010, 8'h5a);
        verify_mode = 1'b1;
        code_protect_n = 1'b1;
        rd(22'h00_0010, 8'h5a);
        $display("test table done");
    endtask : t_table
    task automatic final_report();
        $display("tests %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        {arst_n, cfg_watchdog_enable, cfg_crystal_osc, sleep_instr, kick_watchdog_instr} = '0;
        {global_irq_enable, sw_ctrl_wr, irq_pending, table_read_instr} = '0;
        {seen_rst, seen_vec, pc_in, table_addr, sw_ctrl_wdata, src_cmd, periph_wake_en} = '0;
        {master_clear_pin, flags_rd_clear_n, code_protect_n, verify_mode} = 4'hf;
        watchdog_postscale_sel = 3'h7;
        user_id_bytes = 40'h44_3322_1100;
        prog_mem_data = 8'h5a;
        step(10);
        arst_n = 1'b1;
        t_regs();
        t_table();
        t_noop();
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_crystal();
        t_pin();
        t_wdt();
        final_report();
    end
    // hang guard: nearly five times the expected run
    initial begin
        #320000;
        num_errors++;
        final_report();
    end
endmodule : wsc_watchdog_sleep_wake_control_tb_top
`default_nettype wire
